// file: ecc_err_map.svh
// register offsets, field positions and reset values of the ecc error report block
// assumes a word-indexed register port, one 32-bit word per index
`ifndef ECC_ERR_MAP_SVH
`define ECC_ERR_MAP_SVH
`define IDX_IRQ_CONFIG       8'h82
`define IDX_STATUS_COUNTS    8'h90
`define IDX_ERR_ADDR         8'h91
`define IDX_DROP_ADDR        8'h92
`define IDX_ERR_ADDR_UPPER   8'h93
`define IDX_DROP_ADDR_UPPER  8'h94
`define CFG_GEN_SBE          0
`define CFG_GEN_DBE          1
`define CFG_INTR_EN          2
`define CFG_MASK_SBE         3
`define CFG_MASK_DBE         4
`define CFG_MASK_DROP        5
`define CFG_MASK_CTRL        6
`define CFG_CLEAR            7
`define CFG_RW_MSB           6
`define STS_INTR             0
`define STS_SBE              1
`define STS_DBE              2
`define STS_DROP             3
`define STS_SBE_CNT_LSB      4
`define STS_DBE_CNT_LSB      8
`define STS_DROP_CNT_LSB     12
`define CFG_RESET            7'h00
`define CNT_RESET            4'h0
`define ADDR_RESET           32'h0000_0000
`define UPPER_RESET          3'h0
`define DATA_ZERO            32'h0000_0000
`define BIT_ONE_POS          0
`define BIT_TWO_POS          1
`endif

// file: ecc_err_pkg.sv
// types shared by the ecc error report block
// assumes ecc_err_map.svh supplies the numbers
package ecc_err_pkg;
  typedef struct packed {
    logic        sbe;
    logic        dbe;
    logic        drop;
    logic        ctrl_irq;
  } event_s;
  typedef struct packed {
    logic [2:0]  upper;
    logic [31:0] lower;
  } addr_s;
endpackage

// file: ecc_err_report.sv
// ecc error reporting: write-path error injection, interrupt, sticky flags, counters, addresses
// assumes one clock, event inputs synchronous one-cycle pulses, register port without wait
//
// How it works
// R1 - cfg bit0 flips one write data bit
// R2 - cfg bit1 flips two write data bits
// R3 - cfg bit2 enables the interrupt output
// R4 - cfg bit3 masks single-bit error interrupt
// R5 - cfg bit4 masks double-bit error interrupt
// R6 - cfg bit5 masks dropped correction interrupt
// R7 - cfg bit6 masks controller interrupt input
// R8 - cfg bit7 write clears irq, flags, addresses
// R9 - status bit0 shows pending interrupt
// R10 - status bit1 sticky single-bit error flag
// R11 - status bit2 sticky double-bit error flag
// R12 - status bit3 sticky dropped correction flag
// R13 - status 7:4 wrapping single-bit error count
// R14 - status 11:8 wrapping double-bit error count
// R15 - status 15:12 wrapping dropped count
// R16 - latest sbe/dbe address register, read-only
// R17 - latest dropped correction address, read-only
// R18 - three upper bits of error address
// R19 - three upper bits of dropped address
// R20 - irq is set by enable and an unmasked event in that cycle
// R21 - irq stays set until clear written
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ecc_err_map.svh"
module ecc_err_report #(
  parameter int DATA_W = 64
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // events from the datapath and hard controller
  input  wire ecc_err_pkg::event_s  evt,
  input  wire ecc_err_pkg::addr_s   err_addr,
  input  wire ecc_err_pkg::addr_s   drop_addr,
  // write path
  input  wire logic [DATA_W-1:0]    wr_data_in,
  output logic      [DATA_W-1:0]    wr_data_out,
  // interrupt
  output logic                      ecc_irq
);
  logic [`CFG_RW_MSB:0] cfg_q;
  logic                 clr_q;
  logic                 sbe_q, dbe_q, drop_q;
  logic [3:0]           sbe_cnt_q, dbe_cnt_q, drop_cnt_q;
  ecc_err_pkg::addr_s   err_addr_q, drop_addr_q;
  logic                 irq_q;
  logic                 irq_d;
  logic                 cfg_wr;
  logic [31:0]          rd_d;
  logic [DATA_W-1:0]    flip;

  assign cfg_wr = reg_wr && (reg_addr == `IDX_IRQ_CONFIG);

  // configuration bits, software owned
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= `CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= reg_wdata[`CFG_RW_MSB:0];
    end
  end

  // clear pulse, the stored bit falls back by itself next cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clr_q <= 1'b0;
    end else begin
      clr_q <= cfg_wr && reg_wdata[`CFG_CLEAR]; // see R8
    end
  end

  // sticky flags: a new event in the clear cycle survives the clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sbe_q  <= 1'b0;
      dbe_q  <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      sbe_q  <= evt.sbe  || (sbe_q  && !clr_q); // see R10 see R8
      dbe_q  <= evt.dbe  || (dbe_q  && !clr_q); // see R11
      drop_q <= evt.drop || (drop_q && !clr_q); // see R12
    end
  end

  // wrapping counters; they are not cleared, only the flags, addresses and irq are
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sbe_cnt_q  <= `CNT_RESET;
      dbe_cnt_q  <= `CNT_RESET;
      drop_cnt_q <= `CNT_RESET;
    end else begin
      if (evt.sbe) sbe_cnt_q <= sbe_cnt_q + 4'h1;    // see R13
      if (evt.dbe) dbe_cnt_q <= dbe_cnt_q + 4'h1;    // see R14
      if (evt.drop) drop_cnt_q <= drop_cnt_q + 4'h1; // see R15
    end
  end

  // captured addresses, newest event overwrites
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      err_addr_q  <= '{upper: `UPPER_RESET, lower: `ADDR_RESET};
      drop_addr_q <= '{upper: `UPPER_RESET, lower: `ADDR_RESET};
    end else begin
      if (evt.sbe || evt.dbe) begin
        err_addr_q <= err_addr; // see R16 see R18
      end else if (clr_q) begin
        err_addr_q <= '{upper: `UPPER_RESET, lower: `ADDR_RESET};
      end
      if (evt.drop) begin
        drop_addr_q <= drop_addr; // see R17 see R19
      end else if (clr_q) begin
        drop_addr_q <= '{upper: `UPPER_RESET, lower: `ADDR_RESET};
      end
    end
  end

  // interrupt cause: combinational, enable and unmasked events of this cycle only
  always_comb begin
    irq_d = cfg_q[`CFG_INTR_EN] && ( // see R3 see R20
            (evt.sbe && !cfg_q[`CFG_MASK_SBE]) ||       // see R4
            (evt.dbe && !cfg_q[`CFG_MASK_DBE]) ||       // see R5
            (evt.drop && !cfg_q[`CFG_MASK_DROP]) ||     // see R6
            (evt.ctrl_irq && !cfg_q[`CFG_MASK_CTRL]));  // see R7
  end

  // pending bit behind status bit0; a new cause in the clear cycle beats the clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d || (irq_q && !clr_q); // see R21 see R8
    end
  end

  // pin copy of the pending bit, its own flop so the pin leaves a register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ecc_irq <= 1'b0;
    end else begin
      ecc_irq <= irq_d || (irq_q && !clr_q);
    end
  end

  // error injection mask; registered output costs one cycle of write latency
  always_comb begin
    flip = '0;
    flip[`BIT_ONE_POS] = cfg_q[`CFG_GEN_SBE] || cfg_q[`CFG_GEN_DBE]; // see R1
    flip[`BIT_TWO_POS] = cfg_q[`CFG_GEN_DBE];                        // see R2
  end

  // write data leave through a register, so a cfg write never glitches the path
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_data_out <= '0;
    end else begin
      wr_data_out <= wr_data_in ^ flip;
    end
  end

  // read mux; unmapped indices and reserved bits read zero
  always_comb begin
    rd_d = `DATA_ZERO;
    unique case (reg_addr)
      `IDX_IRQ_CONFIG:      rd_d[`CFG_RW_MSB:0] = cfg_q;
      `IDX_STATUS_COUNTS: begin
        rd_d[`STS_INTR] = irq_q; // see R9
        rd_d[`STS_SBE]  = sbe_q;
        rd_d[`STS_DBE]  = dbe_q;
        rd_d[`STS_DROP] = drop_q;
        rd_d[`STS_SBE_CNT_LSB +: 4]  = sbe_cnt_q;
        rd_d[`STS_DBE_CNT_LSB +: 4]  = dbe_cnt_q;
        rd_d[`STS_DROP_CNT_LSB +: 4] = drop_cnt_q;
      end
      `IDX_ERR_ADDR:        rd_d = err_addr_q.lower;
      `IDX_DROP_ADDR:       rd_d = drop_addr_q.lower;
      `IDX_ERR_ADDR_UPPER:  rd_d[2:0] = err_addr_q.upper;
      `IDX_DROP_ADDR_UPPER: rd_d[2:0] = drop_addr_q.upper;
      default:              rd_d = `DATA_ZERO;
    endcase
  end

  // read data only in the cycle after the strobe, zero otherwise for bus or-ing
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `DATA_ZERO;
    end else begin
      reg_rdata <= reg_rd ? rd_d : `DATA_ZERO;
    end
  end

  // assertions
  property p_irq_masked_sbe;
    @(posedge clk_sys) disable iff (!rst_b)
      (!irq_q && evt.sbe && !evt.dbe && !evt.drop && !evt.ctrl_irq && cfg_q[`CFG_MASK_SBE])
      |=> !ecc_irq;
  endproperty
  a_irq_masked_sbe: assert property (p_irq_masked_sbe) else $error("sbe mask bad"); // see R4

  property p_irq_sbe_sets;
    @(posedge clk_sys) disable iff (!rst_b)
      (evt.sbe && cfg_q[`CFG_INTR_EN] && !cfg_q[`CFG_MASK_SBE]) |=> ecc_irq;
  endproperty
  a_irq_sbe_sets: assert property (p_irq_sbe_sets) else $error("sbe did not raise irq"); // see R20

  property p_irq_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      (ecc_irq && !clr_q) |=> ecc_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear"); // see R21

  property p_clear_drops;
    @(posedge clk_sys) disable iff (!rst_b)
      (cfg_wr && reg_wdata[`CFG_CLEAR]) ##1 !(|evt) |=> (!sbe_q && !dbe_q && !drop_q && !ecc_irq);
  endproperty
  a_clear_drops: assert property (p_clear_drops) else $error("clear left a flag set"); // see R8

  property p_sbe_count;
    @(posedge clk_sys) disable iff (!rst_b)
      evt.sbe |=> (sbe_cnt_q == $past(sbe_cnt_q) + 4'h1);
  endproperty
  a_sbe_count: assert property (p_sbe_count) else $error("sbe count wrong"); // see R13

  property p_dbe_flag;
    @(posedge clk_sys) disable iff (!rst_b)
      evt.dbe |=> dbe_q ##0 (err_addr_q == $past(err_addr));
  endproperty
  a_dbe_flag: assert property (p_dbe_flag) else $error("dbe flag or address missed"); // see R11

  property p_drop_addr;
    @(posedge clk_sys) disable iff (!rst_b)
      evt.drop |=> (drop_addr_q == $past(drop_addr)) && drop_q;
  endproperty
  a_drop_addr: assert property (p_drop_addr) else $error("drop address not captured"); // see R17

  property p_inject_dbe;
    @(posedge clk_sys) disable iff (!rst_b)
      cfg_q[`CFG_GEN_DBE] |=> ($countones(wr_data_out ^ $past(wr_data_in)) == 2);
  endproperty
  a_inject_dbe: assert property (p_inject_dbe) else $error("dbe injection wrong"); // see R2

  property p_irq_disabled;
    @(posedge clk_sys) disable iff (!rst_b)
      (!cfg_q[`CFG_INTR_EN] && !irq_q) |=> !ecc_irq;
  endproperty
  a_irq_disabled: assert property (p_irq_disabled) else $error("irq without enable"); // see R3

  property p_inject_sbe;
    @(posedge clk_sys) disable iff (!rst_b)
      (cfg_q[`CFG_GEN_SBE] && !cfg_q[`CFG_GEN_DBE])
      |=> $onehot(wr_data_out ^ $past(wr_data_in))
          && (wr_data_out[`BIT_ONE_POS] != $past(wr_data_in[`BIT_ONE_POS]));
  endproperty
  a_inject_sbe: assert property (p_inject_sbe) else $error("sbe injection wrong"); // see R1

  property p_inject_off;
    @(posedge clk_sys) disable iff (!rst_b)
      (!cfg_q[`CFG_GEN_SBE] && !cfg_q[`CFG_GEN_DBE]) |=> (wr_data_out == $past(wr_data_in));
  endproperty
  a_inject_off: assert property (p_inject_off) else $error("write data altered"); // see R1

  property p_irq_masked_dbe;
    @(posedge clk_sys) disable iff (!rst_b)
      (!irq_q && evt.dbe && !evt.sbe && !evt.drop && !evt.ctrl_irq && cfg_q[`CFG_MASK_DBE])
      |=> !ecc_irq;
  endproperty
  a_irq_masked_dbe: assert property (p_irq_masked_dbe) else $error("dbe mask bad"); // see R5

  property p_irq_masked_drop;
    @(posedge clk_sys) disable iff (!rst_b)
      (!irq_q && evt.drop && !evt.sbe && !evt.dbe && !evt.ctrl_irq && cfg_q[`CFG_MASK_DROP])
      |=> !ecc_irq;
  endproperty
  a_irq_masked_drop: assert property (p_irq_masked_drop) else $error("drop mask bad"); // see R6

  property p_irq_masked_ctrl;
    @(posedge clk_sys) disable iff (!rst_b)
      (!irq_q && evt.ctrl_irq && !evt.sbe && !evt.dbe && !evt.drop && cfg_q[`CFG_MASK_CTRL])
      |=> !ecc_irq;
  endproperty
  a_irq_masked_ctrl: assert property (p_irq_masked_ctrl) else $error("ctrl mask bad"); // see R7

  property p_irq_dbe_sets;
    @(posedge clk_sys) disable iff (!rst_b)
      (evt.dbe && cfg_q[`CFG_INTR_EN] && !cfg_q[`CFG_MASK_DBE]) |=> ecc_irq;
  endproperty
  a_irq_dbe_sets: assert property (p_irq_dbe_sets) else $error("dbe left irq low"); // see R20

  property p_irq_drop_sets;
    @(posedge clk_sys) disable iff (!rst_b)
      (evt.drop && cfg_q[`CFG_INTR_EN] && !cfg_q[`CFG_MASK_DROP]) |=> ecc_irq;
  endproperty
  a_irq_drop_sets: assert property (p_irq_drop_sets) else $error("drop left irq low"); // see R20

  property p_irq_ctrl_sets;
    @(posedge clk_sys) disable iff (!rst_b)
      (evt.ctrl_irq && cfg_q[`CFG_INTR_EN] && !cfg_q[`CFG_MASK_CTRL]) |=> ecc_irq;
  endproperty
  a_irq_ctrl_sets: assert property (p_irq_ctrl_sets) else $error("ctrl left irq low"); // see R20

  property p_sbe_flag;
    @(posedge clk_sys) disable iff (!rst_b)
      evt.sbe |=> sbe_q ##0 (err_addr_q == $past(err_addr));
  endproperty
  a_sbe_flag: assert property (p_sbe_flag) else $error("sbe flag or address missed"); // see R10

  property p_flag_hold_sbe;
    @(posedge clk_sys) disable iff (!rst_b)
      (sbe_q && !clr_q) |=> sbe_q;
  endproperty
  a_flag_hold_sbe: assert property (p_flag_hold_sbe) else $error("sbe flag lost"); // see R10

  property p_flag_hold_dbe;
    @(posedge clk_sys) disable iff (!rst_b)
      (dbe_q && !clr_q) |=> dbe_q;
  endproperty
  a_flag_hold_dbe: assert property (p_flag_hold_dbe) else $error("dbe flag lost"); // see R11

  property p_flag_hold_drop;
    @(posedge clk_sys) disable iff (!rst_b)
      (drop_q && !clr_q) |=> drop_q;
  endproperty
  a_flag_hold_drop: assert property (p_flag_hold_drop) else $error("drop flag lost"); // see R12

  property p_dbe_count;
    @(posedge clk_sys) disable iff (!rst_b)
      evt.dbe |=> (dbe_cnt_q == $past(dbe_cnt_q) + 4'h1);
  endproperty
  a_dbe_count: assert property (p_dbe_count) else $error("dbe count wrong"); // see R14

  property p_drop_count;
    @(posedge clk_sys) disable iff (!rst_b)
      evt.drop |=> (drop_cnt_q == $past(drop_cnt_q) + 4'h1);
  endproperty
  a_drop_count: assert property (p_drop_count) else $error("drop count wrong"); // see R15

  property p_sbe_count_idle;
    @(posedge clk_sys) disable iff (!rst_b)
      !evt.sbe |=> $stable(sbe_cnt_q);
  endproperty
  a_sbe_count_idle: assert property (p_sbe_count_idle) else $error("sbe count moved"); // see R13

  property p_dbe_count_idle;
    @(posedge clk_sys) disable iff (!rst_b)
      !evt.dbe |=> $stable(dbe_cnt_q);
  endproperty
  a_dbe_count_idle: assert property (p_dbe_count_idle) else $error("dbe count moved"); // see R14

  property p_drop_count_idle;
    @(posedge clk_sys) disable iff (!rst_b)
      !evt.drop |=> $stable(drop_cnt_q);
  endproperty
  a_drop_count_idle: assert property (p_drop_count_idle) else $error("drop count moved"); // see R15

  property p_err_addr_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      (!evt.sbe && !evt.dbe && !clr_q) |=> $stable(err_addr_q);
  endproperty
  a_err_addr_hold: assert property (p_err_addr_hold) else $error("error addr moved"); // see R16

  property p_drop_addr_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      (!evt.drop && !clr_q) |=> $stable(drop_addr_q);
  endproperty
  a_drop_addr_hold: assert property (p_drop_addr_hold) else $error("drop addr moved"); // see R17

  property p_clear_addr;
    @(posedge clk_sys) disable iff (!rst_b)
      (cfg_wr && reg_wdata[`CFG_CLEAR]) ##1 !(|evt)
      |=> (err_addr_q == '0) && (drop_addr_q == '0);
  endproperty
  a_clear_addr: assert property (p_clear_addr) else $error("clear left an address"); // see R8

  property p_status_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (reg_rd && reg_addr == `IDX_STATUS_COUNTS) |=> (reg_rdata[`STS_INTR] == $past(irq_q));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status irq bit wrong"); // see R9
endmodule
`default_nettype wire

// file: ecc_err_report_bench.sv
// self-checking bench of the ecc error report block
// assumes ecc_evt_source stands in for the datapath and hard controller
`timescale 1ns/1ps
`default_nettype none
`include "ecc_err_map.svh"
module ecc_err_report_bench;
  logic clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, go = 0, ecc_irq;
  logic [7:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [63:0] wr_data_in = '0, wr_data_out;
  ecc_err_pkg::event_s evt, kind = '0;
  ecc_err_pkg::addr_s  err_addr, drop_addr, addr = '0;
  int miscompares = 0, check_count = 0;
  ecc_err_report u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .evt(evt), .err_addr(err_addr), .drop_addr(drop_addr),
    .wr_data_in(wr_data_in), .wr_data_out(wr_data_out), .ecc_irq(ecc_irq));
  ecc_evt_source u_src (.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .kind(kind),
    .addr(addr), .evt(evt), .err_addr(err_addr), .drop_addr(drop_addr));
  // free-running clock at 100 ns
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task results;
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cmp(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes changed just after the edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so look there
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 cmp(64'(reg_rdata), 64'(exp));
  endtask
  // waits long enough for the pulse to land in flags, counts and irq
  task ev(input logic [3:0] k, input logic [34:0] a);
    @(posedge clk_sys);
    go <= 1'b1;
    kind <= k;
    addr <= a;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // hang guard: counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(`IDX_STATUS_COUNTS, 32'h0);
    rd(`IDX_IRQ_CONFIG, 32'h0);
    rd(8'h00, 32'h0); // unmapped index
    @(posedge clk_sys) wr_data_in <= 64'h0000_0000_0000_00ff;
    wr(`IDX_IRQ_CONFIG, 32'h1);
    repeat (2) @(posedge clk_sys);
    #1 cmp(wr_data_out, 64'h00fe);
    wr(`IDX_IRQ_CONFIG, 32'h2);
    repeat (2) @(posedge clk_sys);
    #1 cmp(wr_data_out, 64'h00fc);
    wr(`IDX_IRQ_CONFIG, 32'h1fc);
    rd(`IDX_IRQ_CONFIG, 32'h7c);
    wr(`IDX_IRQ_CONFIG, 32'h4);
    ev(4'b1000, 35'h5_1234_5678);
    cmp(64'(ecc_irq), 64'h1);
    rd(`IDX_STATUS_COUNTS, 32'h13);
    rd(`IDX_ERR_ADDR, 32'h1234_5678);
    rd(`IDX_ERR_ADDR_UPPER, 32'h5);
    ev(4'b0010, 35'h2_0000_abcd);
    rd(`IDX_STATUS_COUNTS, 32'h101b);
    rd(`IDX_DROP_ADDR, 32'h0000_abcd);
    rd(`IDX_DROP_ADDR_UPPER, 32'h2);
    cmp(64'(ecc_irq), 64'h1);
    wr(`IDX_IRQ_CONFIG, 32'h84);
    repeat (2) @(posedge clk_sys);
    #1 cmp(64'(ecc_irq), 64'h0);
    rd(`IDX_STATUS_COUNTS, 32'h1010);
    rd(`IDX_ERR_ADDR, 32'h0);
    // each source masked, then unmasked
    for (int i = 0; i < 4; i++) begin
      wr(`IDX_IRQ_CONFIG, 32'h4 | (32'h8 << i));
      ev(4'b1000 >> i, 35'h0_0000_0010);
      cmp(64'(ecc_irq), 64'h0);
      wr(`IDX_IRQ_CONFIG, 32'h84 | (32'h8 << i));
      wr(`IDX_IRQ_CONFIG, 32'h4);
      ev(4'b1000 >> i, 35'h0_0000_0020);
      cmp(64'(ecc_irq), 64'h1);
      wr(`IDX_IRQ_CONFIG, 32'h84);
    end
    // sixteen more of each count must wrap back to the same value
    wr(`IDX_IRQ_CONFIG, 32'h0);
    for (int n = 0; n < 16; n++) ev(4'b1110, 35'h0_0000_0040);
    cmp(64'(ecc_irq), 64'h0);
    rd(`IDX_STATUS_COUNTS, 32'h323e);
    results();
  end
endmodule
`default_nettype wire

// file: ecc_evt_source.sv
// behavioural source of ecc events and addresses for the error report block
// assumes the bench requests one pulse at a time on go
`timescale 1ns/1ps
`default_nettype none
module ecc_evt_source (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // request from the bench
  input  wire logic                 go,
  input  wire ecc_err_pkg::event_s  kind,
  input  wire ecc_err_pkg::addr_s   addr,
  // towards the design
  output var ecc_err_pkg::event_s   evt,
  output var ecc_err_pkg::addr_s    err_addr,
  output var ecc_err_pkg::addr_s    drop_addr
);
  // one-cycle pulse; addresses flip when idle so stale values never pass as valid
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      evt       <= '0;
      err_addr  <= '0;
      drop_addr <= '0;
    end else if (go) begin
      evt       <= kind;
      err_addr  <= addr;
      drop_addr <= addr;
    end else begin
      evt       <= '0;
      err_addr  <= ~err_addr;
      drop_addr <= ~drop_addr;
    end
  end
endmodule
`default_nettype wire
